// ===== include/fpu_regs_pkg.sv
`default_nettype none
package fpu_regs_pkg;
  // register selects on the coprocessor move port
  localparam logic [1:0] SEL_OPERAND = 2'h0;
  localparam logic [1:0] SEL_CONTROL = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_CAPTURE = 2'h3;
  // write operations: move, literal and, literal or
  localparam logic [1:0] OP_MOVE = 2'h0;
  localparam logic [1:0] OP_AND = 2'h1;
  localparam logic [1:0] OP_OR = 2'h2;
  // operand registers
  localparam int OPERAND_W = 32;
  localparam int OPERAND_N = 32;
  localparam int OPERAND_AW = 5;
  localparam logic [31:0] OPERAND_RESET = 32'h0000_0000;
  // control register layout
  localparam int CTRL_W = 16;
  localparam int EXC_W = 7;
  localparam logic [15:0] CTRL_IMPL = 16'h0F7F;
  localparam logic [15:0] CTRL_RESET = 16'h007F;
  localparam int CTRL_MASK_LSB = 0;
  localparam int CTRL_RND_LSB = 8;
  localparam int CTRL_RND_MSB = 9;
  localparam int CTRL_FTZ = 10;
  localparam int CTRL_SAZ = 11;
  // exception index, shared by mask, flag and sticky fields
  localparam int EXC_ILLEGAL = 0;
  localparam int EXC_DIVZERO = 1;
  localparam int EXC_OVERFLOW = 2;
  localparam int EXC_UNDERFLOW = 3;
  localparam int EXC_INEXACT = 4;
  localparam int EXC_OVERSIZE = 5;
  localparam int EXC_DENORMAL = 6;
  // rounding encodings
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_ZERO = 2'h1;
  localparam logic [1:0] RND_POS = 2'h2;
  localparam logic [1:0] RND_NEG = 2'h3;
  // status register layout
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam int STAT_DYN_LSB = 0;
  localparam int STAT_STICKY_LSB = 8;
  localparam int STAT_CMP_LSB = 16;
  localparam int STAT_CLS_LSB = 24;
  localparam int CMP_W = 4;
  localparam int CMP_GT = 3;
  localparam int CMP_LT = 2;
  localparam int CMP_EQ = 1;
  localparam int CMP_UN = 0;
  localparam int CLS_W = 5;
  localparam int CLS_SUB = 4;
  localparam int CLS_INF = 3;
  localparam int CLS_NEG = 2;
  localparam int CLS_ZERO = 1;
  localparam int CLS_NAN = 0;
  // capture register layout
  localparam int CAP_EN = 0;
  localparam int CAP_ZERO = 1;
  localparam int CAP_ADDR_LSB = 2;
  localparam int CAP_ADDR_MSB = 23;
  localparam int CAP_ADDR_W = 22;
  localparam logic [21:0] CAP_ADDR_RESET = 22'h00_0000;
  // single precision fields
  localparam int F_SIGN = 31;
  localparam int F_EXP_MSB = 30;
  localparam int F_EXP_LSB = 23;
  localparam int F_MAN_MSB = 22;
  localparam logic [7:0] F_EXP_ONES = 8'hFF;
  localparam logic [7:0] F_EXP_ZERO = 8'h00;
  localparam logic [22:0] F_MAN_ZERO = 23'h00_0000;
endpackage
`default_nettype wire

// ===== logic/fpu_control_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module fpu_control_status_regs (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // coprocessor register writes
  input wire logic i_wr_en,
  input wire logic [1:0] i_wr_sel,
  input wire logic [1:0] i_wr_op,
  input wire logic [4:0] i_wr_idx,
  input wire logic [31:0] i_wr_data,
  // coprocessor register reads
  input wire logic [1:0] i_rd_sel,
  input wire logic [4:0] i_rd_idx,
  output logic [31:0] o_rd_data,
  // instruction retirement
  input wire logic i_retire_valid,
  input wire logic [6:0] i_retire_exc,
  input wire logic [23:0] i_retire_pc,
  input wire logic i_retire_is_compare,
  input wire logic i_retire_is_classify,
  input wire logic [31:0] i_src_first,
  input wire logic [31:0] i_src_second,
  // result writeback
  input wire logic i_result_we,
  input wire logic [4:0] i_result_idx,
  input wire logic [31:0] i_result_data,
  // operand conditioning toward the functional block
  input wire logic [31:0] i_operand_raw,
  output logic [31:0] o_operand_cond,
  // mode and condition outputs
  output logic [1:0] o_rounding_select,
  output logic o_flush_active,
  output logic o_zero_inputs_active,
  output logic [3:0] o_branch_cond,
  output logic o_fpu_exception
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [6:0] dyn;
    logic [6:0] sticky;
    logic [3:0] cmp;
    logic [4:0] cls;
    logic [21:0] cap_addr;
    logic cap_en;
    logic captured;
    logic [1:0] rd_sel;
    logic [31:0] csr_rdata;
  } regs_s;

  regs_s st_q;
  regs_s st_d;
  logic [31:0] mem_rdata;
  logic mem_we;
  logic [4:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] status_view;
  logic [31:0] capture_view;
  logic [31:0] cur_view;
  logic [31:0] wval;

  ////////////////////////////////////////////////////////////////////////////
  // float helpers

  function automatic logic f_is_nan(input logic [31:0] v);
    return (v[fpu_regs_pkg::F_EXP_MSB:fpu_regs_pkg::F_EXP_LSB] == fpu_regs_pkg::F_EXP_ONES)
      && (v[fpu_regs_pkg::F_MAN_MSB:0] != fpu_regs_pkg::F_MAN_ZERO);
  endfunction

  function automatic logic f_is_inf(input logic [31:0] v);
    return (v[fpu_regs_pkg::F_EXP_MSB:fpu_regs_pkg::F_EXP_LSB] == fpu_regs_pkg::F_EXP_ONES)
      && (v[fpu_regs_pkg::F_MAN_MSB:0] == fpu_regs_pkg::F_MAN_ZERO);
  endfunction

  function automatic logic f_is_zero(input logic [31:0] v);
    return (v[fpu_regs_pkg::F_EXP_MSB:fpu_regs_pkg::F_EXP_LSB] == fpu_regs_pkg::F_EXP_ZERO)
      && (v[fpu_regs_pkg::F_MAN_MSB:0] == fpu_regs_pkg::F_MAN_ZERO);
  endfunction

  function automatic logic f_is_sub(input logic [31:0] v);
    return (v[fpu_regs_pkg::F_EXP_MSB:fpu_regs_pkg::F_EXP_LSB] == fpu_regs_pkg::F_EXP_ZERO)
      && (v[fpu_regs_pkg::F_MAN_MSB:0] != fpu_regs_pkg::F_MAN_ZERO);
  endfunction

  // x below y, both ordered; signed zeros compare equal
  function automatic logic f_less(input logic [31:0] x, input logic [31:0] y);
    logic sx;
    logic sy;
    sx = x[fpu_regs_pkg::F_SIGN];
    sy = y[fpu_regs_pkg::F_SIGN];
    if (f_is_zero(x) && f_is_zero(y)) begin
      return 1'b0;
    end else if (sx != sy) begin
      return sx;
    end else if (!sx) begin
      return x[fpu_regs_pkg::F_EXP_MSB:0] < y[fpu_regs_pkg::F_EXP_MSB:0];
    end else begin
      return x[fpu_regs_pkg::F_EXP_MSB:0] > y[fpu_regs_pkg::F_EXP_MSB:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register views

  assign status_view = {3'h0, st_q.cls, 4'h0, st_q.cmp, 1'b0, st_q.sticky, 1'b0, st_q.dyn};
  assign capture_view = {8'h00, st_q.cap_addr, 1'b0, st_q.cap_en};

  always_comb begin
    case (i_wr_sel)
      fpu_regs_pkg::SEL_CONTROL: cur_view = {16'h0000, st_q.ctrl};
      fpu_regs_pkg::SEL_STATUS: cur_view = status_view;
      fpu_regs_pkg::SEL_CAPTURE: cur_view = capture_view;
      default: cur_view = 32'h0000_0000;
    endcase
  end

  always_comb begin
    case (i_wr_op)
      fpu_regs_pkg::OP_AND: wval = cur_view & i_wr_data;
      fpu_regs_pkg::OP_OR: wval = cur_view | i_wr_data;
      default: wval = i_wr_data;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    st_d.rd_sel = i_rd_sel;
    case (i_rd_sel)
      fpu_regs_pkg::SEL_CONTROL: st_d.csr_rdata = {16'h0000, st_q.ctrl};
      fpu_regs_pkg::SEL_STATUS: st_d.csr_rdata = status_view;
      fpu_regs_pkg::SEL_CAPTURE: st_d.csr_rdata = capture_view;
      default: st_d.csr_rdata = 32'h0000_0000;
    endcase
    // software writes
    if (i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_CONTROL) begin
      st_d.ctrl = wval[15:0] & fpu_regs_pkg::CTRL_IMPL;
    end
    if (i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_STATUS) begin
      st_d.dyn = wval[fpu_regs_pkg::STAT_DYN_LSB +: fpu_regs_pkg::EXC_W];
      st_d.sticky = wval[fpu_regs_pkg::STAT_STICKY_LSB +: fpu_regs_pkg::EXC_W];
      st_d.cmp = wval[fpu_regs_pkg::STAT_CMP_LSB +: fpu_regs_pkg::CMP_W];
      st_d.cls = wval[fpu_regs_pkg::STAT_CLS_LSB +: fpu_regs_pkg::CLS_W];
    end
    if (i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_CAPTURE) begin
      st_d.cap_addr = wval[fpu_regs_pkg::CAP_ADDR_MSB:fpu_regs_pkg::CAP_ADDR_LSB];
      st_d.cap_en = wval[fpu_regs_pkg::CAP_EN];
      st_d.captured = 1'b0;
    end
    // retirement updates win over a software write in the same cycle, except sticky, which ORs the new flags into the written value
    if (i_retire_valid) begin
      st_d.dyn = i_retire_exc;
      st_d.sticky = st_d.sticky | i_retire_exc;
      if (i_retire_is_compare) begin
        st_d.cmp[fpu_regs_pkg::CMP_UN] = f_is_nan(i_src_first) | f_is_nan(i_src_second);
        st_d.cmp[fpu_regs_pkg::CMP_GT] = !st_d.cmp[fpu_regs_pkg::CMP_UN]
          && f_less(i_src_first, i_src_second);
        st_d.cmp[fpu_regs_pkg::CMP_LT] = !st_d.cmp[fpu_regs_pkg::CMP_UN]
          && f_less(i_src_second, i_src_first);
        st_d.cmp[fpu_regs_pkg::CMP_EQ] = !st_d.cmp[fpu_regs_pkg::CMP_UN]
          && !f_less(i_src_first, i_src_second)
          && !f_less(i_src_second, i_src_first);
      end
      if (i_retire_is_classify) begin
        st_d.cls[fpu_regs_pkg::CLS_SUB] = f_is_sub(i_src_first);
        st_d.cls[fpu_regs_pkg::CLS_INF] = f_is_inf(i_src_first);
        st_d.cls[fpu_regs_pkg::CLS_NEG] = i_src_first[fpu_regs_pkg::F_SIGN];
        st_d.cls[fpu_regs_pkg::CLS_ZERO] = f_is_zero(i_src_first);
        st_d.cls[fpu_regs_pkg::CLS_NAN] = f_is_nan(i_src_first);
      end
      if (st_q.cap_en && !st_q.captured && (i_retire_exc != 7'h00)) begin
        st_d.cap_addr = i_retire_pc[fpu_regs_pkg::CAP_ADDR_MSB:fpu_regs_pkg::CAP_ADDR_LSB];
        st_d.captured = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
      st_q.ctrl <= fpu_regs_pkg::CTRL_RESET;
      st_q.cap_addr <= fpu_regs_pkg::CAP_ADDR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand registers

  assign mem_we = i_result_we | (i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_OPERAND);
  assign mem_waddr = i_result_we ? i_result_idx : i_wr_idx;
  assign mem_wdata = i_result_we ? i_result_data : i_wr_data;

  fpu_operand_mem #(
    .W(fpu_regs_pkg::OPERAND_W),
    .D(fpu_regs_pkg::OPERAND_N),
    .AW(fpu_regs_pkg::OPERAND_AW)
  ) u_operand_mem (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(i_rd_idx),
    .o_rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_rd_data = (st_q.rd_sel == fpu_regs_pkg::SEL_OPERAND) ? mem_rdata : st_q.csr_rdata;
  assign o_rounding_select = st_q.ctrl[fpu_regs_pkg::CTRL_RND_MSB:fpu_regs_pkg::CTRL_RND_LSB];
  assign o_flush_active = st_q.ctrl[fpu_regs_pkg::CTRL_FTZ]
    & st_q.ctrl[fpu_regs_pkg::EXC_UNDERFLOW];
  assign o_zero_inputs_active = st_q.ctrl[fpu_regs_pkg::CTRL_SAZ];
  assign o_operand_cond = (o_zero_inputs_active && f_is_sub(i_operand_raw))
    ? {i_operand_raw[fpu_regs_pkg::F_SIGN], 31'h0000_0000} : i_operand_raw;
  assign o_branch_cond = st_q.cmp;
  assign o_fpu_exception = |(st_q.dyn & ~st_q.ctrl[fpu_regs_pkg::EXC_W-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  sequence s_unmasked_exc;
    i_retire_valid && ((i_retire_exc & ~st_q.ctrl[6:0]) != 7'h00);
  endsequence

  property p_irq_follows;
    s_unmasked_exc and !(i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_CONTROL) |=> o_fpu_exception;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("unmasked exception gave no irq");

  property p_masked_quiet;
    i_retire_valid && ((i_retire_exc & ~st_q.ctrl[6:0]) == 7'h00) && !i_wr_en |=> !o_fpu_exception;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked exception raised irq");

  property p_reset_masks;
    $rose(i_resetn) |-> st_q.ctrl[6:0] == 7'h7F;
  endproperty
  a_reset_masks: assert property (p_reset_masks) else $error("masks not set after reset");

  property p_flush_qual;
    i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_CONTROL && i_wr_op == fpu_regs_pkg::OP_MOVE
      |=> o_flush_active == ($past(i_wr_data[10]) && $past(i_wr_data[3]));
  endproperty
  a_flush_qual: assert property (p_flush_qual) else $error("flush mode not qualified");

  property p_rounding_write;
    i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_CONTROL && i_wr_op == fpu_regs_pkg::OP_MOVE
      |=> o_rounding_select == $past(i_wr_data[9:8]);
  endproperty
  a_rounding_write: assert property (p_rounding_write) else $error("rounding field wrong");

  property p_dyn_rewrite;
    i_retire_valid |=> st_q.dyn == $past(i_retire_exc);
  endproperty
  a_dyn_rewrite: assert property (p_dyn_rewrite) else $error("dynamic flags not rewritten");

  property p_sticky_hold;
    !(i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_STATUS)
      |=> (($past(st_q.sticky) & ~st_q.sticky) == 7'h00);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag cleared by hw");

  property p_unordered;
    i_retire_valid && i_retire_is_compare && f_is_nan(i_src_second)
      |=> o_branch_cond == 4'h1;
  endproperty
  a_unordered: assert property (p_unordered) else $error("nan compare not unordered");

  property p_classify_zero;
    i_retire_valid && i_retire_is_classify && f_is_zero(i_src_first)
      |=> st_q.cls[fpu_regs_pkg::CLS_ZERO] && !st_q.cls[fpu_regs_pkg::CLS_NAN];
  endproperty
  a_classify_zero: assert property (p_classify_zero) else $error("zero not classified");

  property p_cap_bit1;
    i_rd_sel == fpu_regs_pkg::SEL_CAPTURE |=> !o_rd_data[1];
  endproperty
  a_cap_bit1: assert property (p_cap_bit1) else $error("capture bit 1 read as one");

  sequence s_already_captured;
    st_q.captured && !(i_wr_en && i_wr_sel == fpu_regs_pkg::SEL_CAPTURE);
  endsequence

  property p_first_only;
    s_already_captured |=> $stable(st_q.cap_addr);
  endproperty
  a_first_only: assert property (p_first_only) else $error("capture address overwritten");

  property p_zero_inputs;
    o_zero_inputs_active && f_is_sub(i_operand_raw)
      |-> o_operand_cond[30:0] == 31'h0000_0000
      && o_operand_cond[31] == i_operand_raw[31];
  endproperty
  a_zero_inputs: assert property (p_zero_inputs) else $error("denormal input not zeroed");
endmodule
`default_nettype wire

// ===== logic/fpu_operand_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fpu_operand_mem #(
  parameter int W = 32,
  parameter int D = 32,
  parameter int AW = 5
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  // read port, data one cycle later
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  typedef struct packed {
    logic [D-1:0][W-1:0] words;
    logic [W-1:0] rdata;
  } mem_s;

  mem_s st_q;
  mem_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.rdata = st_q.words[i_raddr];
    if (i_we) begin
      st_d.words[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
endmodule
`default_nettype wire

// ===== sim/fpu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpu_host_model (
  // clock
  input wire logic i_clk_sys,
  // register moves
  output logic o_wr_en,
  output logic [1:0] o_wr_sel,
  output logic [1:0] o_wr_op,
  output logic [4:0] o_wr_idx,
  output logic [31:0] o_wr_data,
  output logic [1:0] o_rd_sel,
  output logic [4:0] o_rd_idx,
  input wire logic [31:0] i_rd_data,
  // retirement
  output logic o_ret_valid,
  output logic [6:0] o_ret_exc,
  output logic [23:0] o_ret_pc,
  output logic o_ret_cmp,
  output logic o_ret_cls,
  output logic [31:0] o_src_a,
  output logic [31:0] o_src_b
);
  initial begin
    {o_wr_en, o_wr_sel, o_wr_op, o_wr_idx, o_wr_data, o_rd_sel, o_rd_idx} = '0;
    {o_ret_valid, o_ret_exc, o_ret_pc, o_ret_cmp, o_ret_cls, o_src_a, o_src_b} = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one write, held for one edge
  task automatic wr(input logic [1:0] s, input logic [31:0] d, input logic [4:0] i = 5'h00,
                    input logic [1:0] op = fpu_regs_pkg::OP_MOVE);
    @(posedge i_clk_sys);
    o_wr_en <= 1'b1;
    o_wr_sel <= s;
    o_wr_op <= op;
    o_wr_idx <= i;
    o_wr_data <= d;
    @(posedge i_clk_sys);
    o_wr_en <= 1'b0;
    #1;
  endtask
  // read answers one cycle after the select is taken
  task automatic rd(input logic [1:0] s, output logic [31:0] d, input logic [4:0] i = 5'h00);
    @(posedge i_clk_sys);
    o_rd_sel <= s;
    o_rd_idx <= i;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    #1;
    d = i_rd_data;
  endtask
  // one retiring instruction
  task automatic ret(input logic [6:0] e, input logic [23:0] pc, input logic c, input logic k,
                     input logic [31:0] a, input logic [31:0] b);
    @(posedge i_clk_sys);
    o_ret_valid <= 1'b1;
    o_ret_exc <= e;
    o_ret_pc <= pc;
    o_ret_cmp <= c;
    o_ret_cls <= k;
    o_src_a <= a;
    o_src_b <= b;
    @(posedge i_clk_sys);
    o_ret_valid <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_fpu_control_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_fpu_control_status_regs;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] raw = 32'h0000_0000;
  logic res_we = 1'b0;
  logic [4:0] res_idx = 5'h00;
  logic [31:0] res_data = 32'h0000_0000;
  int fail_count = 0;
  int check_count = 0;
  logic wr_en, ret_valid, ret_cmp, ret_cls, flush, zin, fexc;
  logic [1:0] wr_sel, wr_op, rd_sel, rnd;
  logic [4:0] wr_idx, rd_idx;
  logic [6:0] ret_exc;
  logic [23:0] ret_pc;
  logic [31:0] wr_data, rd_data, src_a, src_b, cond;
  logic [3:0] br;
  always #50 clk = ~clk;
  fpu_host_model host (.i_clk_sys(clk), .o_wr_en(wr_en), .o_wr_sel(wr_sel), .o_wr_op(wr_op),
    .o_wr_idx(wr_idx), .o_wr_data(wr_data), .o_rd_sel(rd_sel), .o_rd_idx(rd_idx),
    .i_rd_data(rd_data), .o_ret_valid(ret_valid), .o_ret_exc(ret_exc), .o_ret_pc(ret_pc),
    .o_ret_cmp(ret_cmp), .o_ret_cls(ret_cls), .o_src_a(src_a), .o_src_b(src_b));
  fpu_control_status_regs DUT (.i_clk_sys(clk), .i_resetn(resetn), .i_wr_en(wr_en),
    .i_wr_sel(wr_sel), .i_wr_op(wr_op), .i_wr_idx(wr_idx), .i_wr_data(wr_data),
    .i_rd_sel(rd_sel), .i_rd_idx(rd_idx), .o_rd_data(rd_data), .i_retire_valid(ret_valid),
    .i_retire_exc(ret_exc), .i_retire_pc(ret_pc), .i_retire_is_compare(ret_cmp),
    .i_retire_is_classify(ret_cls), .i_src_first(src_a), .i_src_second(src_b),
    .i_result_we(res_we), .i_result_idx(res_idx), .i_result_data(res_data),
    .i_operand_raw(raw), .o_operand_cond(cond), .o_rounding_select(rnd),
    .o_flush_active(flush), .o_zero_inputs_active(zin), .o_branch_cond(br),
    .o_fpu_exception(fexc));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic rchk(input string n, input logic [1:0] s, input logic [31:0] e);
    logic [31:0] d;
    host.rd(s, d, 5'h1F);
    chk(n, e, d);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk("control", fpu_regs_pkg::SEL_CONTROL, 32'h0000_007F);
    rchk("status", fpu_regs_pkg::SEL_STATUS, 32'h0000_0000);
    rchk("capture", fpu_regs_pkg::SEL_CAPTURE, 32'h0000_0000);
    rchk("operand", fpu_regs_pkg::SEL_OPERAND, 32'h0000_0000);
    chk("exception", 32'h0, {31'h0, fexc});
  endtask
  task automatic t_control;
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'hFFFF_FFFF);
    rchk("control", fpu_regs_pkg::SEL_CONTROL, 32'h0000_0F7F);
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_0408);
    chk("flush", 32'h1, {31'h0, flush});
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_0400);
    chk("flush", 32'h0, {31'h0, flush});
    for (int r = 0; r < 4; r++) begin
      host.wr(fpu_regs_pkg::SEL_CONTROL, 32'(r) << 8);
      chk("rounding", 32'(r), {30'h0, rnd});
    end
    chk("zero inputs", 32'h0, {31'h0, zin});
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_0800);
    chk("zero inputs", 32'h1, {31'h0, zin});
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_0400, 5'h00, fpu_regs_pkg::OP_OR);
    chk("flush unmasked", 32'h0, {31'h0, flush});
    rchk("control or", fpu_regs_pkg::SEL_CONTROL, 32'h0000_0C00);
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_FBFF, 5'h00, fpu_regs_pkg::OP_AND);
    rchk("control and", fpu_regs_pkg::SEL_CONTROL, 32'h0000_0800);
    @(posedge clk) raw <= 32'h807F_FFFF;
    #1 chk("cond denormal", 32'h8000_0000, cond);
    @(posedge clk) raw <= 32'h3F80_0000;
    #1 chk("cond normal", 32'h3F80_0000, cond);
  endtask
  task automatic t_exc;
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_0000);
    for (int i = 0; i < 7; i++) begin
      host.wr(fpu_regs_pkg::SEL_STATUS, 32'h0);
      host.ret(7'(1 << i), 24'h0, 1'b0, 1'b0, 32'h0, 32'h0);
      rchk("flag pair", fpu_regs_pkg::SEL_STATUS, (32'h101 << i));
      chk("exception", 32'h1, {31'h0, fexc});
    end
    host.wr(fpu_regs_pkg::SEL_STATUS, 32'h0);
    host.wr(fpu_regs_pkg::SEL_CAPTURE, 32'h1);
    host.ret(7'h08, 24'h000104, 1'b0, 1'b0, 32'h0, 32'h0);
    host.ret(7'h01, 24'h000200, 1'b0, 1'b0, 32'h0, 32'h0);
    rchk("status", fpu_regs_pkg::SEL_STATUS, 32'h0000_0901);
    rchk("capture", fpu_regs_pkg::SEL_CAPTURE, 32'h0000_0105);
    host.wr(fpu_regs_pkg::SEL_CONTROL, 32'h0000_0001);
    chk("masked", 32'h0, {31'h0, fexc});
    host.ret(7'h00, 24'h000300, 1'b0, 1'b0, 32'h0, 32'h0);
    rchk("status", fpu_regs_pkg::SEL_STATUS, 32'h0000_0900);
    host.wr(fpu_regs_pkg::SEL_STATUS, 32'h0);
    rchk("sticky clear", fpu_regs_pkg::SEL_STATUS, 32'h0);
    host.wr(fpu_regs_pkg::SEL_CAPTURE, 32'hFFFF_FFFF);
    rchk("capture", fpu_regs_pkg::SEL_CAPTURE, 32'h00FF_FFFD);
  endtask
  task automatic t_cmp;
    logic [31:0] a[6] = '{32'h3F80_0000, 32'h4000_0000, 32'h4000_0000, 32'h0000_0000,
                          32'h7FC0_0000, 32'h3F80_0000};
    logic [31:0] b[6] = '{32'h4000_0000, 32'h3F80_0000, 32'h4000_0000, 32'h8000_0000,
                          32'h3F80_0000, 32'h7F80_0001};
    logic [3:0] e[6] = '{4'h8, 4'h4, 4'h2, 4'h2, 4'h1, 4'h1};
    for (int i = 0; i < 6; i++) begin
      host.ret(7'h00, 24'h0, 1'b1, 1'b0, a[i], b[i]);
      chk("branch cond", {28'h0, e[i]}, {28'h0, br});
      rchk("compare", fpu_regs_pkg::SEL_STATUS, {12'h0, e[i], 16'h0});
    end
  endtask
  task automatic t_cls;
    logic [31:0] a[6] = '{32'h0000_0001, 32'hFF80_0000, 32'h8000_0000, 32'h7F80_0001,
                          32'hFFC0_0000, 32'h3F80_0000};
    logic [4:0] e[6] = '{5'h10, 5'h0C, 5'h06, 5'h01, 5'h05, 5'h00};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      host.ret(7'h00, 24'h0, 1'b0, 1'b1, a[i], 32'h0);
      host.rd(fpu_regs_pkg::SEL_STATUS, d);
      chk("classify", {27'h0, e[i]}, {27'h0, d[28:24]});
    end
  endtask
  task automatic t_oper;
    logic [31:0] d;
    host.wr(fpu_regs_pkg::SEL_OPERAND, 32'hA5A5_5A5A, 5'h1F);
    host.wr(fpu_regs_pkg::SEL_OPERAND, 32'h0123_4567, 5'h00);
    host.rd(fpu_regs_pkg::SEL_OPERAND, d, 5'h1F);
    chk("operand 31", 32'hA5A5_5A5A, d);
    host.rd(fpu_regs_pkg::SEL_OPERAND, d, 5'h00);
    chk("operand 0", 32'h0123_4567, d);
    @(posedge clk);
    res_we <= 1'b1;
    res_idx <= 5'h05;
    res_data <= 32'h3C3C_C3C3;
    @(posedge clk);
    res_we <= 1'b0;
    host.rd(fpu_regs_pkg::SEL_OPERAND, d, 5'h05);
    chk("result 5", 32'h3C3C_C3C3, d);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_control();
    t_exc();
    t_cmp();
    t_cls();
    t_oper();
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
